/* logic/plcc_axil_slave.sv */
// AXI4-Lite slave front end turning bus transfers into single-cycle strobes
`timescale 1ns/1ps
`include "plcc_cfg.svh"
module plcc_axil_slave
	import plcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [11:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output plcc_wr_s         wr,
	input  wire logic        wr_err,
	output plcc_rd_s         rd,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_err
);
	typedef struct packed {
		logic        aw_rdy;
		logic        w_rdy;
		logic        aw_full;
		logic        w_full;
		logic [11:0] waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        ar_rdy;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} plcc_axil_s;

	plcc_axil_s s_q;
	plcc_axil_s s_d;

	// Address and data are taken in either order; the commit waits for both
	always_comb begin
		s_d = s_q;
		wr  = '0;
		rd  = '0;
		if (awvalid && s_q.aw_rdy) begin
			s_d.aw_full = 1'b1;
			s_d.aw_rdy  = 1'b0;
			s_d.waddr   = awaddr;
		end
		if (wvalid && s_q.w_rdy) begin
			s_d.w_full = 1'b1;
			s_d.w_rdy  = 1'b0;
			s_d.wdata  = wdata;
			s_d.wstrb  = wstrb;
		end
		if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
			wr.en       = 1'b1;
			wr.addr     = s_q.waddr;
			wr.data     = s_q.wdata;
			wr.strb     = s_q.wstrb;
			s_d.aw_full = 1'b0;
			s_d.w_full  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = wr_err ? `PLCC_RESP_SLVERR : `PLCC_RESP_OKAY;
		end
		// Ready stays low until the response is taken, so one write at a time
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
			s_d.aw_rdy = 1'b1;
			s_d.w_rdy  = 1'b1;
		end
		if (arvalid && s_q.ar_rdy) begin
			rd.en      = 1'b1;
			rd.addr    = araddr;
			s_d.ar_rdy = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_data;
			s_d.rresp  = rd_err ? `PLCC_RESP_SLVERR : `PLCC_RESP_OKAY;
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
			s_d.ar_rdy = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q        <= '0;
			s_q.aw_rdy <= 1'b1;
			s_q.w_rdy  <= 1'b1;
			s_q.ar_rdy <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready = s_q.aw_rdy;
	assign wready  = s_q.w_rdy;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	assign arready = s_q.ar_rdy;
	assign rvalid  = s_q.rvalid;
	assign rdata   = s_q.rdata;
	assign rresp   = s_q.rresp;
endmodule

/* logic/plcc_cfg.svh */
// Offsets, field positions, reset values and counts of the link capability/control bank
`ifndef PLCC_CFG_SVH
`define PLCC_CFG_SVH

`define PLCC_ADDR_W          12
`define PLCC_LINK_CAP_OFS    12'h04c
`define PLCC_LINK_CTL_OFS    12'h050

`define PLCC_RESP_OKAY       2'h0
`define PLCC_RESP_SLVERR     2'h2

`define PLCC_CAP_SPEED       3:0
`define PLCC_CAP_WIDTH       9:4
`define PLCC_CAP_PMS         11:10
`define PLCC_CAP_L0S_LAT     14:12
`define PLCC_CAP_L1_LAT      17:15
`define PLCC_CAP_PORT        31:24

`define PLCC_CTL_PM          1:0
`define PLCC_CTL_RCB         3
`define PLCC_CTL_OFF         4
`define PLCC_CTL_RETRAIN     5
`define PLCC_CTL_SHARED_REFCLK_FLAG        6
`define PLCC_CTL_LONG_SYNC_MODE       7

`define PLCC_SPEED_CODE      4'h1
`define PLCC_WIDTH_RST       6'h08
`define PLCC_PMS_CODE        2'h3
`define PLCC_L0S_LAT_SEP     3'h5
`define PLCC_L0S_LAT_COMMON  3'h3
`define PLCC_L1_LAT_RST      3'h2
`define PLCC_PM_RST          2'h0

`define PLCC_EXT_FTS_COUNT   13'h1000
`define PLCC_STRAP_SETTLE    2'h3

`endif

/* logic/plcc_link_regs.sv */
// Link capability and link control registers of one switch port
`timescale 1ns/1ps
`include "plcc_cfg.svh"

// Contract
// - Max speed field always reads the fixed 2.5 Gbps code 0x1.
// - Max lane count, bits 9:4, resets to eight and may be lowered.
// - Any lane count other than 1, 2, 4 or 8 trains one lane.
// - Power management support, bits 11:10, always reads 0x3.
// - Standby exit latency reads 0x5 with separate clocks, 0x3 with common.
// - Deep idle exit latency, bits 17:15, resets to code 0x2.
// - Bits 31:24 are read-only and give this port's index.
// - Power control bits 1:0 enable none, L0s, L1 or both.
// - Power control resets disabled; a start-up memory load may replace it.
// - Completion boundary bit 3 always reads zero.
// - Link off bit set on a downstream port keeps its link disabled.
// - Link off bit is fixed at zero on the upstream port.
// - Writing one to the retrain bit sends the training machine to Recovery.
// - Retrain bit always reads zero.
// - Upstream retrain writes count only while the unlock bit is set.
// - Shared reference clock flag, bit 6, is plain read-write.
// - Long sync mode sends 4096 FTS then one SKP per standby exit.
module plcc_link_regs
	import plcc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [11:0]   awaddr,
	input  wire logic          wvalid,
	output logic               wready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	output logic               bvalid,
	input  wire logic          bready,
	output logic [1:0]         bresp,
	input  wire logic          arvalid,
	output logic               arready,
	input  wire logic [11:0]   araddr,
	output logic               rvalid,
	input  wire logic          rready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	input  wire logic [1:0]    port_sel_pin,
	input  wire logic          upstream_write_unlock,
	input  wire plcc_pm_load_s pm_load,
	input  wire logic          l0s_exit_start,
	input  wire logic [7:0]    n_fts,
	input  wire logic          os_ready,
	output logic [5:0]         train_width,
	output logic               link_off,
	output logic               retrain_to_recovery,
	output logic               l0s_entry_en,
	output logic               l1_entry_en,
	output logic               os_valid,
	output plcc_os_e           os_kind,
	output logic               port_is_upstream
);
	plcc_top_s  s_q;
	plcc_top_s  s_d;
	plcc_wr_s   wr;
	plcc_rd_s   rd;
	logic       wr_err;
	logic       rd_err;
	logic [31:0] rd_data;
	logic [1:0] strap_q;
	logic       upstream;
	logic       wr_cap;
	logic       wr_ctl;
	logic [31:0] cap_word;
	logic [31:0] ctl_word;
	logic [31:0] cur_word;
	logic [31:0] merged;

	// Bus front end; register decode and side effects live here
	plcc_axil_slave u_bus (
		.clk     (clk),
		.nrst    (nrst),
		.awvalid (awvalid),
		.awready (awready),
		.awaddr  (awaddr),
		.wvalid  (wvalid),
		.wready  (wready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.bvalid  (bvalid),
		.bready  (bready),
		.bresp   (bresp),
		.arvalid (arvalid),
		.arready (arready),
		.araddr  (araddr),
		.rvalid  (rvalid),
		.rready  (rready),
		.rdata   (rdata),
		.rresp   (rresp),
		.wr      (wr),
		.wr_err  (wr_err),
		.rd      (rd),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// Port index straps come from pins and must be synchronised first
	plcc_sync #(
		.W (2)
	) u_strap (
		.clk  (clk),
		.nrst (nrst),
		.d    (port_sel_pin),
		.q    (strap_q)
	);

	// Port zero is the upstream port of the switch
	assign upstream = (s_q.port_idx == 2'h0);

	// Lane count to train with; reserved encodings fall back to one lane
	function automatic logic [5:0] lanes_to_train(input logic [5:0] cap);
		logic [5:0] res;
		res = 6'h01;
		case (cap)
			6'h01, 6'h02, 6'h04, 6'h08: res = cap;
			default: res = 6'h01;
		endcase
		return res;
	endfunction

	// Byte-lane merge so partial writes keep untouched bytes
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] cur,
		input logic [31:0] wd,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = cur;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Capability word; fixed fields are built here, never stored
	always_comb begin
		cap_word                   = '0;
		cap_word[`PLCC_CAP_SPEED]  = `PLCC_SPEED_CODE;
		cap_word[`PLCC_CAP_WIDTH]  = s_q.lane_cap;
		cap_word[`PLCC_CAP_PMS]    = `PLCC_PMS_CODE;
		cap_word[`PLCC_CAP_L0S_LAT] = s_q.shared_refclk_flag ? `PLCC_L0S_LAT_COMMON
		                                       : `PLCC_L0S_LAT_SEP;
		cap_word[`PLCC_CAP_L1_LAT] = s_q.l1_lat;
		cap_word[`PLCC_CAP_PORT]   = {6'h00, s_q.port_idx};
	end

	// Control word; retrain and completion boundary always read zero
	always_comb begin
		ctl_word                      = '0;
		ctl_word[`PLCC_CTL_PM]        = s_q.pm_ctl;
		ctl_word[`PLCC_CTL_RCB]       = 1'b0;
		ctl_word[`PLCC_CTL_OFF]       = s_q.off;
		ctl_word[`PLCC_CTL_RETRAIN]   = 1'b0;
		ctl_word[`PLCC_CTL_SHARED_REFCLK_FLAG]      = s_q.shared_refclk_flag;
		ctl_word[`PLCC_CTL_LONG_SYNC_MODE]     = s_q.long_sync_mode;
	end

	// Word-aligned decode; the two low address bits are ignored
	assign wr_cap = (wr.addr[11:2] == `PLCC_LINK_CAP_OFS >> 2);
	assign wr_ctl = (wr.addr[11:2] == `PLCC_LINK_CTL_OFS >> 2);
	assign wr_err = wr.en && !wr_cap && !wr_ctl;

	// Read mux; unmapped reads return zero with an error response
	always_comb begin
		rd_data = '0;
		rd_err  = 1'b0;
		if (rd.addr[11:2] == `PLCC_LINK_CAP_OFS >> 2) begin
			rd_data = cap_word;
		end else if (rd.addr[11:2] == `PLCC_LINK_CTL_OFS >> 2) begin
			rd_data = ctl_word;
		end else begin
			rd_err = rd.en;
		end
	end

	assign cur_word = wr_cap ? cap_word : ctl_word;
	assign merged   = merge_bytes(cur_word, wr.data, wr.strb);

	// Next state: straps, start-up load, bus writes, then the exit sequencer
	always_comb begin
		s_d         = s_q;
		s_d.retrain = 1'b0;

		// Let the synchroniser settle before the index is frozen for good
		if (!s_q.strap_done) begin
			if (s_q.strap_cnt == `PLCC_STRAP_SETTLE) begin
				s_d.port_idx   = strap_q;
				s_d.strap_done = 1'b1;
			end else begin
				s_d.strap_cnt = s_q.strap_cnt + 2'h1;
			end
		end

		// Start-up memory load of power control; a bus write below wins
		if (pm_load.valid) begin
			s_d.pm_ctl = pm_load.value;
		end

		// Lockable capability fields change only while unlocked
		if (wr.en && wr_cap && upstream_write_unlock) begin
			s_d.lane_cap = merged[`PLCC_CAP_WIDTH];
			s_d.l1_lat   = merged[`PLCC_CAP_L1_LAT];
		end

		// Control write; unwritable and reserved bits are simply dropped
		if (wr.en && wr_ctl) begin
			s_d.pm_ctl = merged[`PLCC_CTL_PM];
			s_d.off    = merged[`PLCC_CTL_OFF];
			s_d.shared_refclk_flag   = merged[`PLCC_CTL_SHARED_REFCLK_FLAG];
			s_d.long_sync_mode  = merged[`PLCC_CTL_LONG_SYNC_MODE];
			if (merged[`PLCC_CTL_RETRAIN] && (!upstream || upstream_write_unlock)) begin
				s_d.retrain = 1'b1;
			end
		end

		// Upstream port can never hold the link off
		if (s_d.port_idx == 2'h0) begin
			s_d.off = 1'b0;
		end

		s_d.train_width = lanes_to_train(s_d.lane_cap);

		// Standby exit ordered-set sequencer; mode is latched at the start
		case (s_q.seq)
			PLCC_SEQ_IDLE: begin
				if (l0s_exit_start && (s_q.long_sync_mode || n_fts != 8'h00)) begin
					s_d.seq_long = s_q.long_sync_mode;
					s_d.os_left  = s_q.long_sync_mode ? `PLCC_EXT_FTS_COUNT
					                         : {5'h00, n_fts};
					s_d.os_kind  = PLCC_OS_FTS;
					s_d.os_valid = 1'b1;
					s_d.seq      = PLCC_SEQ_FTS;
				end
			end
			PLCC_SEQ_FTS: begin
				if (os_ready) begin
					if (s_q.os_left == 13'h0001) begin
						if (s_q.seq_long) begin
							s_d.os_kind = PLCC_OS_SKP;
							s_d.seq     = PLCC_SEQ_SKP;
						end else begin
							s_d.os_valid = 1'b0;
							s_d.seq      = PLCC_SEQ_IDLE;
						end
					end else begin
						s_d.os_left = s_q.os_left - 13'h0001;
					end
				end
			end
			PLCC_SEQ_SKP: begin
				// Exactly one SKP, then back to idle
				if (os_ready) begin
					s_d.os_valid = 1'b0;
					s_d.os_kind  = PLCC_OS_FTS;
					s_d.seq      = PLCC_SEQ_IDLE;
				end
			end
			default: begin
				s_d.seq      = PLCC_SEQ_IDLE;
				s_d.os_valid = 1'b0;
			end
		endcase
	end

	// State register with documented defaults
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q             <= '0;
			s_q.lane_cap    <= `PLCC_WIDTH_RST;
			s_q.train_width <= `PLCC_WIDTH_RST;
			s_q.l1_lat      <= `PLCC_L1_LAT_RST;
			s_q.pm_ctl      <= `PLCC_PM_RST;
			s_q.seq         <= PLCC_SEQ_IDLE;
			s_q.os_kind     <= PLCC_OS_FTS;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state flops, except port_is_upstream, decoded from strap_done and port_idx
	assign train_width         = s_q.train_width;
	assign link_off            = s_q.off;
	assign retrain_to_recovery = s_q.retrain;
	assign l0s_entry_en        = s_q.pm_ctl[0];
	assign l1_entry_en         = s_q.pm_ctl[1];
	assign os_valid            = s_q.os_valid;
	assign os_kind             = s_q.os_kind;
	assign port_is_upstream    = s_q.strap_done && (s_q.port_idx == 2'h0);
endmodule

/* logic/plcc_pkg.sv */
// Types shared by the link capability/control bank
package plcc_pkg;

	typedef struct packed {
		logic        en;
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} plcc_wr_s;

	typedef struct packed {
		logic        en;
		logic [11:0] addr;
	} plcc_rd_s;

	typedef struct packed {
		logic       valid;
		logic [1:0] value;
	} plcc_pm_load_s;

	typedef enum logic [1:0] {
		PLCC_SEQ_IDLE,
		PLCC_SEQ_FTS,
		PLCC_SEQ_SKP
	} plcc_seq_e;

	typedef enum logic {
		PLCC_OS_FTS,
		PLCC_OS_SKP
	} plcc_os_e;

	typedef struct packed {
		logic [1:0]  strap_cnt;
		logic        strap_done;
		logic [1:0]  port_idx;
		logic [5:0]  lane_cap;
		logic [2:0]  l1_lat;
		logic [1:0]  pm_ctl;
		logic        off;
		logic        shared_refclk_flag;
		logic        long_sync_mode;
		logic [5:0]  train_width;
		logic        retrain;
		plcc_seq_e   seq;
		logic [12:0] os_left;
		logic        os_valid;
		plcc_os_e    os_kind;
		logic        seq_long;
	} plcc_top_s;

endpackage

/* logic/plcc_sync.sv */
// Two-stage synchroniser for strap pins
`timescale 1ns/1ps
module plcc_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} plcc_sync_s;

	plcc_sync_s s_q;
	plcc_sync_s s_d;

	// Only the second stage is read outside; the first may go metastable
	always_comb begin
		s_d    = s_q;
		s_d.s1 = d;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.s2;
endmodule

/* tb/plcc_link_peer.sv */
// Ordered-set consumer and exit trigger standing in for the training machine
`timescale 1ns/1ps
module plcc_link_peer
	import plcc_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     nrst,
	input  wire logic     go,
	input  wire logic     os_valid,
	input  wire plcc_os_e os_kind,
	output logic          os_ready,
	output logic          l0s_exit_start,
	output int            fts,
	output int            skp
);
	// Random stalls make the sequencer hold each set; start is a one-cycle pulse
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			os_ready <= 1'b0;
			l0s_exit_start <= 1'b0;
		end else begin
			os_ready <= ($urandom % 3) != 0;
			l0s_exit_start <= go;
		end
	end
	// Tally of sets taken in one exit
	always @(posedge clk) begin
		if (go) begin
			fts <= 0;
			skp <= 0;
		end else if (os_valid && os_ready) begin
			fts <= fts + (os_kind == PLCC_OS_FTS);
			skp <= skp + (os_kind == PLCC_OS_SKP);
		end
	end
endmodule

/* tb/plcc_link_regs_sva.sv */
// Concurrent checks on the ports of the link capability/control bank
`timescale 1ns/1ps
`include "plcc_cfg.svh"
module plcc_link_regs_sva
	import plcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        arvalid,
	input  wire logic        arready,
	input  wire logic [11:0] araddr,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata,
	input  wire logic        bvalid,
	input  wire logic        upstream_write_unlock,
	input  wire logic        os_ready,
	input  wire logic        l0s_exit_start,
	input  wire logic [5:0]  train_width,
	input  wire logic        link_off,
	input  wire logic        retrain_to_recovery,
	input  wire logic        l0s_entry_en,
	input  wire logic        l1_entry_en,
	input  wire logic        os_valid,
	input  wire plcc_os_e    os_kind,
	input  wire logic        port_is_upstream
);
	logic [11:0] ra_q;
	logic [12:0] fts_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Address of the read in flight, so returned data is judged per register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ra_q <= 12'h000;
		else if (arvalid && arready)
			ra_q <= araddr;
	end
	// FTS sets taken since this exit began; a start while busy is ignored, so no clear then
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			fts_q <= 13'h0000;
		else if (l0s_exit_start && !os_valid)
			fts_q <= 13'h0000;
		else if (os_valid && os_ready && os_kind == PLCC_OS_FTS)
			fts_q <= fts_q + 13'h0001;
	end
	sequence s_rd_cap;
		rvalid && ra_q == `PLCC_LINK_CAP_OFS;
	endsequence
	sequence s_rd_ctl;
		rvalid && ra_q == `PLCC_LINK_CTL_OFS && !bvalid;
	endsequence
	sequence s_skp_take;
		os_valid && os_ready && os_kind == PLCC_OS_SKP;
	endsequence
	a_fixed_caps: assert property (s_rd_cap |-> rdata[3:0] == 4'h1 && rdata[11:10] == 2'h3)
		else $error("fixed capability field wrong");
	a_cap_reserved: assert property (s_rd_cap |-> rdata[23:18] == 6'h00 && rdata[14:12] inside {3'h3, 3'h5})
		else $error("capability reserved or latency wrong");
	a_ctl_zero_bits: assert property (s_rd_ctl |-> rdata[31:8] == 24'h0 && rdata[5:2] == {1'b0, rdata[4], 2'h0})
		else $error("control fixed-zero bit set");
	a_pm_enables: assert property (s_rd_ctl |-> rdata[1:0] == {l1_entry_en, l0s_entry_en})
		else $error("entry enables differ from field");
	a_off_follows: assert property (s_rd_ctl |-> rdata[4] == link_off)
		else $error("link off output differs from bit");
	a_upstream_on: assert property (port_is_upstream |-> !link_off)
		else $error("upstream link disabled");
	a_width_legal: assert property (train_width inside {6'h01, 6'h02, 6'h04, 6'h08})
		else $error("illegal training width");
	a_retrain_pulse: assert property (retrain_to_recovery |-> $rose(bvalid) ##1 !retrain_to_recovery)
		else $error("retrain pulse not tied to write response");
	a_up_retrain_lock: assert property (retrain_to_recovery && port_is_upstream |-> upstream_write_unlock)
		else $error("upstream retrain while locked");
	a_os_hold: assert property (os_valid && !os_ready |=> os_valid && $stable(os_kind))
		else $error("ordered set dropped before taken");
	a_skp_count: assert property (os_valid && os_kind == PLCC_OS_SKP |-> fts_q == 13'h1000)
		else $error("SKP not after 4096 FTS");
	a_skp_single: assert property (s_skp_take |=> !os_valid)
		else $error("sets continue after SKP");
endmodule
bind plcc_link_regs plcc_link_regs_sva u_sva (.clk, .nrst, .arvalid, .arready, .araddr, .rvalid,
	.rdata, .bvalid, .upstream_write_unlock, .os_ready, .l0s_exit_start, .train_width, .link_off,
	.retrain_to_recovery, .l0s_entry_en, .l1_entry_en, .os_valid, .os_kind, .port_is_upstream);

/* tb/plcc_link_regs_tb.sv */
// Self-checking bench for the link capability/control bank
`timescale 1ns/1ps
`include "plcc_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, g); end end
module plcc_link_regs_tb
	import plcc_pkg::*;
;
	localparam logic [11:0] CAP = `PLCC_LINK_CAP_OFS;
	localparam logic [11:0] CTL = `PLCC_LINK_CTL_OFS;
	logic          clk, nrst, awvalid, wvalid, bready, arvalid, rready, go;
	logic [11:0]   awaddr, araddr;
	logic [31:0]   wdata, rdata;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp, port_sel_pin;
	logic          awready, wready, bvalid, arready, rvalid, upstream_write_unlock;
	logic          l0s_exit_start, os_ready, os_valid, retrain_to_recovery, link_off;
	logic          l0s_entry_en, l1_entry_en, port_is_upstream;
	logic [7:0]    n_fts;
	logic [5:0]    train_width;
	plcc_pm_load_s pm_load;
	plcc_os_e      os_kind;
	int            fails, checks, rt_n, fts, skp;
	plcc_link_regs u_dut (.clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
		.rresp, .port_sel_pin, .upstream_write_unlock, .pm_load, .l0s_exit_start, .n_fts,
		.os_ready, .train_width, .link_off, .retrain_to_recovery, .l0s_entry_en, .l1_entry_en,
		.os_valid, .os_kind, .port_is_upstream);
	plcc_link_peer u_peer (.clk, .nrst, .go, .os_valid, .os_kind, .os_ready, .l0s_exit_start,
		.fts, .skp);
	function automatic logic [31:0] cap_exp(logic [7:0] p, logic [5:0] w, logic cc);
		return {p, 6'h00, 3'h2, cc ? 3'h3 : 3'h5, 2'h3, w, 4'h1};
	endfunction
	function automatic logic [5:0] tw_exp(logic [5:0] w);
		return (w inside {6'h01, 6'h02, 6'h04, 6'h08}) ? w : 6'h01;
	endfunction
	// Write with address and data offered together, each released once taken
	task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
		logic aw;
		logic w;
		aw = 1;
		w = 1;
		@(posedge clk);
		awvalid <= 1;
		wvalid <= 1;
		awaddr <= a;
		wdata <= d;
		while (aw || w) begin
			@(posedge clk);
			aw = aw && !awready;
			w = w && !wready;
			awvalid <= aw;
			wvalid <= w;
		end
		bready <= 1;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 0;
		`CHK("bresp", er, bresp)
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] er);
		@(posedge clk);
		arvalid <= 1;
		araddr <= a;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 0;
		rready <= 1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 0;
		`CHK("rdata", e, rdata)
		`CHK("rresp", er, rresp)
	endtask
	// Strap must be steady well before the index freezes
	task automatic boot(logic [1:0] p);
		nrst <= 0;
		port_sel_pin <= p;
		repeat (4) @(posedge clk);
		nrst <= 1;
		repeat (6) @(posedge clk);
	endtask
	task automatic exitseq(int nf, int ns);
		go <= 1;
		@(posedge clk);
		go <= 0;
		repeat (3) @(posedge clk);
		while (os_valid === 1'b1) @(posedge clk);
		`CHK("fts", nf, fts)
		`CHK("skp", ns, skp)
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Retrain pulses seen, across resets as well
	always @(posedge clk) if (retrain_to_recovery === 1'b1) rt_n++;
	// Longest test is the 4096-set exit at about 1.5 cycles per set; 40k cycles leaves margin
	initial begin
		#200000;
		fails++;
		conclude();
	end
	initial begin
		logic [31:0] d;
		logic [5:0]  w;
		int          e;
		{awvalid, wvalid, bready, arvalid, rready, go, upstream_write_unlock} = 7'h00;
		{awaddr, araddr, wdata} = 56'h0;
		wstrb = 4'hf;
		pm_load = '{1'b0, 2'h0};
		n_fts = 8'h05;
		fails = 0;
		checks = 0;
		rt_n = 0;
		e = 0;
		void'($urandom(32'h75c1));
		boot(2'h1);
		rd(CAP, cap_exp(8'h01, 6'h08, 1'b0), 2'h0);
		rd(CTL, 32'h0, 2'h0);
		`CHK("upstream", 1'b0, port_is_upstream)
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = $urandom | ((i == 0) ? 32'h20 : 32'h0);
			e += d[5];
			wr(CTL, d, 2'h0);
			rd(CTL, d & 32'h00d3, 2'h0);
			`CHK("ctl outs", {d[4], d[1:0]}, {link_off, l1_entry_en, l0s_entry_en})
			rd(CAP, cap_exp(8'h01, 6'h08, d[6]), 2'h0);
		end
		`CHK("retrains", e, rt_n)
		$display("test control done");
		for (int v = 0; v < 4; v++) begin
			pm_load <= '{1'b1, 2'(v)};
			@(posedge clk);
			pm_load <= '{1'b0, 2'h0};
			rd(CTL, (d & 32'h00d0) | v, 2'h0);
		end
		$display("test load done");
		upstream_write_unlock <= 1;
		for (int i = 0; i < 11; i++) begin
			w = (i == 10) ? 6'h3f : 6'(i);
			wr(CAP, ($urandom & 32'hfffc7c0f) | (32'(w) << 4) | 32'h10000, 2'h0);
			rd(CAP, cap_exp(8'h01, w, d[6]), 2'h0);
			`CHK("width", tw_exp(w), train_width)
		end
		upstream_write_unlock <= 0;
		wr(CAP, 32'h80, 2'h0);
		rd(CAP, cap_exp(8'h01, 6'h3f, d[6]), 2'h0);
		wr(12'h100, $urandom, 2'h2);
		rd(12'h100, 32'h0, 2'h2);
		$display("test capability done");
		wr(CTL, 32'h80, 2'h0);
		exitseq(4096, 1);
		n_fts <= 8'($urandom_range(20, 1));
		wr(CTL, 32'h0, 2'h0);
		exitseq(n_fts, 0);
		$display("test sync done");
		boot(2'h0);
		rd(CAP, cap_exp(8'h00, 6'h08, 1'b0), 2'h0);
		`CHK("upstream", 1'b1, port_is_upstream)
		e = rt_n;
		wr(CTL, 32'h30, 2'h0);
		rd(CTL, 32'h0, 2'h0);
		`CHK("retrains", e, rt_n)
		upstream_write_unlock <= 1;
		wr(CTL, 32'h20, 2'h0);
		@(posedge clk);
		`CHK("retrains", e + 1, rt_n)
		$display("test upstream done");
		conclude();
	end
endmodule
